// *** hw/ptp_defs.svh ***
// register map, field positions, function codes and timing counts of the pulse output unit
`ifndef PTP_DEFS_SVH
`define PTP_DEFS_SVH

// register byte offsets (low address byte only)
`define PTP_OFF_FUNC 8'h00
`define PTP_OFF_FREQ 8'h04
`define PTP_OFF_DUTY 8'h08
`define PTP_OFF_CTRL 8'h0C
`define PTP_OFF_ERR 8'h10
`define PTP_OFF_IRQSTAT 8'h14
`define PTP_OFF_IRQMASK 8'h18

// control and error field positions
`define PTP_CTRL_ENABLE 0
`define PTP_ERR_PWIDTH 0
`define PTP_ERR_DUTY 1
`define PTP_ERR_FREQ 2
`define PTP_ERR_W 3

// function selection codes
`define PTP_FUNC_ROT 16'h0003
`define PTP_FUNC_STEP 16'h0004
`define PTP_FUNC_PWM 16'h0001

// reset values
`define PTP_RST_16 16'h0000
`define PTP_RST_ERR 3'h0

// frequency and duty limits
`define PTP_FREQ_MIN 16'h0032
`define PTP_FREQ_MAX 16'h1388
`define PTP_DUTY_MAX 16'h0064
`define PTP_PERCENT 32'h0000_0064

// timing: clock rate in Hz, least pulse width in microseconds
`define PTP_CLK_HZ 32'h02FA_F080
`define PTP_US_PER_S 32'h000F_4240
`define PTP_MIN_PULSE_US 32'h0000_0064
`define PTP_PHASE_FULL (`PTP_CLK_HZ)
`define PTP_PHASE_HALF (`PTP_CLK_HZ / 32'h0000_0002)
`define PTP_DUTY_UNIT (`PTP_CLK_HZ / `PTP_PERCENT)
`define PTP_US_PER_PCT (`PTP_US_PER_S / `PTP_PERCENT)

`endif

// *** hw/ptp_pkg.sv ***
// types shared by the pulse output unit
package ptp_pkg;

  typedef enum logic [3:0] {
    PTP_MODE_IDLE = 4'b0001,
    PTP_MODE_ROT = 4'b0010,
    PTP_MODE_STEP = 4'b0100,
    PTP_MODE_PWM = 4'b1000
  } ptp_mode_e;

  typedef enum logic [1:0] {
    PTP_BUS_ADDR = 2'b01,
    PTP_BUS_DATA = 2'b10
  } ptp_bus_e;

  typedef struct packed {
    ptp_bus_e phase;
    logic [7:0] addr;
    logic write;
    logic readyOut;
    logic resp;
    logic [31:0] rdata;
  } ptp_bus_s;

  typedef struct packed {
    logic [25:0] acc;
    logic on;
  } ptp_phase_s;

  typedef struct packed {
    logic [15:0] funcSel;
    logic [15:0] freqSet;
    logic [15:0] dutySet;
    logic enable;
    logic [15:0] activeFreq;
    logic activeValid;
    logic [6:0] activeDuty;
    logic [2:0] errFlags;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic pulsePri;
    logic pulseSec;
    logic irq;
  } ptp_main_s;

endpackage

// *** hw/ptp_ahb_if.sv ***
// ahb-lite slave front end: one wait state, registered read data
`include "ptp_defs.svh"
module ptp_ahb_if import ptp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstSyncN,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [7:0] regAddr,
  output logic regWr,
  input wire logic [31:0] rdData
);

  ptp_bus_s q;
  ptp_bus_s d;

  // address phase capture, then one data-phase cycle with ready low
  always_comb begin
    d = q;
    case (q.phase)
      PTP_BUS_ADDR: begin
        if (hsel && htrans[1] && hready) begin
          d.phase = PTP_BUS_DATA;
          d.addr = haddr[7:0];
          d.write = hwrite && (hsize == 3'h2);
          d.readyOut = 1'b0;
        end
      end
      PTP_BUS_DATA: begin
        d.phase = PTP_BUS_ADDR;
        d.readyOut = 1'b1;
        d.rdata = q.write ? 32'h0000_0000 : rdData;
        d.write = 1'b0;
      end
      default: begin
        d.phase = PTP_BUS_ADDR;
        d.readyOut = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '{phase: PTP_BUS_ADDR, addr: 8'h00, write: 1'b0, readyOut: 1'b1,
             resp: 1'b0, rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  assign hreadyout = q.readyOut;
  assign hrdata = q.rdata;
  assign hresp = q.resp;
  assign regAddr = q.addr;
  assign regWr = (q.phase == PTP_BUS_DATA) && q.write; // hwdata stands in this cycle

endmodule // ptp_ahb_if

// *** hw/ptp_phase_gen.sv ***
// phase accumulator: step per clock is the frequency in hz, wraps at the clock rate
`include "ptp_defs.svh"
module ptp_phase_gen import ptp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstSyncN,
  input wire logic run,
  input wire logic [15:0] stepHz,
  input wire logic [25:0] onThresh,
  output logic phaseOn
);

  ptp_phase_s q;
  ptp_phase_s d;
  logic [26:0] sum;

  // wrap keeps the average period exact; jitter is one clock
  always_comb begin
    d = q;
    sum = {1'b0, q.acc} + {11'h000, stepHz};
    if (!run) begin
      d.acc = 26'h000_0000; // period restarts from its start
      d.on = 1'b0;
    end else begin
      d.on = q.acc < onThresh;
      if (sum >= `PTP_PHASE_FULL) begin
        d.acc = 26'(sum - 27'(`PTP_PHASE_FULL));
      end else begin
        d.acc = sum[25:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '{acc: 26'h000_0000, on: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign phaseOn = q.on;

endmodule // ptp_phase_gen

// *** hw/ptp_pulse_unit.sv ***
// pulse train and pwm output unit with ahb-lite registers
// Notes on behaviour
// R1: pulse train at 50 to 5000 hz, 1 hz
// R2: rotation mode: positive on primary, negative secondary
// R3: step mode: pulses primary, direction high if negative
// R4: pulses only while output enable flag set
// R5: new frequency magnitude applies while enabled
// R6: software keeps sign fixed while enabled
// R7: bad value or sign flip: error, keep old
// R8: error flags clear themselves once condition passes
// R9: function code 3 selects rotation mode
// R10: function code 1 selects pwm mode
// R11: pwm duty 0 to 100 percent, 1 percent
// R12: new duty applies while pwm enabled
// R13: software sets pwm frequency before enabling
// R14: on or off under 100 us: width error
// R15: bad pwm value: error flag, keep old duty
// R16: disabled outputs low, period restarts on enable
`include "ptp_defs.svh"
module ptp_pulse_unit import ptp_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic pulseOutPrimary,
  output logic pulseOutSecondary,
  output logic irq
);

  logic [1:0] rstSync_q;
  logic rstSyncN;
  ptp_main_s q;
  ptp_main_s d;
  logic [7:0] regAddr;
  logic regWr;
  logic [31:0] rdData;
  logic phaseOn;
  logic run;
  logic [15:0] stepHz;
  logic [25:0] onThresh;
  ptp_mode_e mode;
  logic modePulse;
  logic freqOk;
  logic dutyOk;
  logic widthOk;
  logic [2:0] errNow;

  // magnitude of a signed frequency setting
  function automatic logic [15:0] magOf(input logic [15:0] v);
    magOf = v[15] ? 16'(16'h0000 - v) : v;
  endfunction

  // magnitude within the allowed frequency band
  function automatic logic bandOk(input logic [15:0] m);
    bandOk = (m >= `PTP_FREQ_MIN) && (m <= `PTP_FREQ_MAX);
  endfunction

  // true when a pulse of pct percent of a period is at least the least width
  function automatic logic spanOk(input logic [6:0] pct, input logic [15:0] hz);
    spanOk = ({25'h000_0000, pct} * `PTP_US_PER_PCT) >= (`PTP_MIN_PULSE_US * {16'h0000, hz});
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync_q[1];

  ptp_ahb_if u_bus (
    .clk_sys(clk_sys),
    .rstSyncN(rstSyncN),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .regAddr(regAddr),
    .regWr(regWr),
    .rdData(rdData)
  );

  // function code decode
  always_comb begin
    case (q.funcSel)
      `PTP_FUNC_ROT: mode = PTP_MODE_ROT; // R9
      `PTP_FUNC_STEP: mode = PTP_MODE_STEP;
      `PTP_FUNC_PWM: mode = PTP_MODE_PWM; // R10
      default: mode = PTP_MODE_IDLE;
    endcase
  end
  assign modePulse = (mode == PTP_MODE_ROT) || (mode == PTP_MODE_STEP);

  // validity of the written settings
  always_comb begin
    if (modePulse) begin
      freqOk = bandOk(magOf(q.freqSet)) &&
               !(q.enable && q.activeValid && (q.freqSet[15] != q.activeFreq[15])); // R7
    end else if (mode == PTP_MODE_PWM) begin
      freqOk = !q.freqSet[15] && bandOk(q.freqSet); // R15
    end else begin
      freqOk = 1'b1;
    end
    dutyOk = (mode != PTP_MODE_PWM) || (q.dutySet <= `PTP_DUTY_MAX); // R15
    widthOk = (mode != PTP_MODE_PWM) || !dutyOk || !q.activeValid ||
              (q.dutySet == 16'h0000) || (q.dutySet == `PTP_DUTY_MAX) ||
              (spanOk(q.dutySet[6:0], q.activeFreq) &&
               spanOk(7'(`PTP_DUTY_MAX - q.dutySet), q.activeFreq)); // R14
    errNow = 3'h0;
    errNow[`PTP_ERR_FREQ] = !freqOk;
    errNow[`PTP_ERR_DUTY] = !dutyOk;
    errNow[`PTP_ERR_PWIDTH] = !widthOk;
  end

  // phase generator steering
  assign run = q.enable && q.activeValid && (mode != PTP_MODE_IDLE); // R4 R16
  assign stepHz = magOf(q.activeFreq); // R1 R5
  assign onThresh = (mode == PTP_MODE_PWM) ?
                    26'({25'h000_0000, q.activeDuty} * `PTP_DUTY_UNIT) : // R11
                    26'(`PTP_PHASE_HALF);

  ptp_phase_gen u_phase (
    .clk_sys(clk_sys),
    .rstSyncN(rstSyncN),
    .run(run),
    .stepHz(stepHz),
    .onThresh(onThresh),
    .phaseOn(phaseOn)
  );

  // register read mux
  always_comb begin
    rdData = 32'h0000_0000;
    case (regAddr)
      `PTP_OFF_FUNC: rdData = {16'h0000, q.funcSel};
      `PTP_OFF_FREQ: rdData = {16'h0000, q.freqSet};
      `PTP_OFF_DUTY: rdData = {16'h0000, q.dutySet};
      `PTP_OFF_CTRL: rdData = {31'h0000_0000, q.enable};
      `PTP_OFF_ERR: rdData = {29'h0000_0000, q.errFlags};
      `PTP_OFF_IRQSTAT: rdData = {29'h0000_0000, q.irqStat};
      `PTP_OFF_IRQMASK: rdData = {29'h0000_0000, q.irqMask};
      default: rdData = 32'h0000_0000;
    endcase
  end

  // register writes, live settings, error flags, interrupt and outputs
  always_comb begin
    d = q;
    if (regWr) begin
      case (regAddr)
        `PTP_OFF_FUNC: d.funcSel = hwdata[15:0];
        `PTP_OFF_FREQ: d.freqSet = hwdata[15:0];
        `PTP_OFF_DUTY: d.dutySet = hwdata[15:0];
        `PTP_OFF_CTRL: d.enable = hwdata[`PTP_CTRL_ENABLE];
        `PTP_OFF_IRQSTAT: d.irqStat = q.irqStat & ~hwdata[2:0];
        `PTP_OFF_IRQMASK: d.irqMask = hwdata[2:0];
        default: d.enable = q.enable;
      endcase
    end
    // take a valid frequency; pwm frequency only while stopped
    if (freqOk && (modePulse || ((mode == PTP_MODE_PWM) && !q.enable))) begin
      d.activeFreq = q.freqSet; // R5 R7
      d.activeValid = 1'b1;
    end
    if ((mode == PTP_MODE_PWM) && dutyOk) begin
      d.activeDuty = q.dutySet[6:0]; // R12 R15
    end
    d.errFlags = errNow; // R8
    d.irqStat = d.irqStat | (errNow & ~q.errFlags); // new error wins over clear
    d.irq = |(d.irqStat & d.irqMask);
    // output pins; both low while disabled
    d.pulsePri = 1'b0;
    d.pulseSec = 1'b0;
    if (run) begin
      case (mode)
        PTP_MODE_ROT: begin
          d.pulsePri = phaseOn && !q.activeFreq[15]; // R2
          d.pulseSec = phaseOn && q.activeFreq[15]; // R2
        end
        PTP_MODE_STEP: begin
          d.pulsePri = phaseOn; // R3
          d.pulseSec = q.activeFreq[15]; // R3
        end
        PTP_MODE_PWM: d.pulsePri = phaseOn; // R11
        default: d.pulsePri = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q <= '{funcSel: `PTP_RST_16, freqSet: `PTP_RST_16, dutySet: `PTP_RST_16,
             enable: 1'b0, activeFreq: `PTP_RST_16, activeValid: 1'b0,
             activeDuty: 7'h00, errFlags: `PTP_RST_ERR, irqStat: `PTP_RST_ERR,
             irqMask: `PTP_RST_ERR, pulsePri: 1'b0, pulseSec: 1'b0, irq: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pulseOutPrimary = q.pulsePri;
  assign pulseOutSecondary = q.pulseSec;
  assign irq = q.irq;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  chk_disabled_low: assert property ( // R16
    !q.enable |=> !q.pulsePri && !q.pulseSec)
    else $error("output active while disabled");

  chk_enable_gates: assert property ( // R4
    !run ##1 !run |=> !q.pulsePri)
    else $error("primary pulse without running train");

  chk_rot_side: assert property ( // R2
    (mode == PTP_MODE_ROT) && !q.activeFreq[15] |=> !q.pulseSec)
    else $error("secondary pulse for positive frequency");

  chk_dir_level: assert property ( // R3
    (mode == PTP_MODE_STEP) && run && q.activeFreq[15] |=> q.pulseSec)
    else $error("direction low for negative frequency");

  chk_freq_bad: assert property ( // R7
    modePulse && !freqOk |=> q.errFlags[`PTP_ERR_FREQ] && $stable(q.activeFreq))
    else $error("bad frequency taken or not flagged");

  chk_freq_apply: assert property ( // R5
    modePulse && freqOk |=> q.activeFreq == $past(q.freqSet))
    else $error("valid frequency not applied");

  chk_err_selfclear: assert property ( // R8
    (mode == PTP_MODE_IDLE) ##1 (mode == PTP_MODE_IDLE) |-> q.errFlags == 3'h0)
    else $error("error flag stuck after condition passed");

  chk_func_rot: assert property ( // R9
    regWr && (regAddr == `PTP_OFF_FUNC) && (hwdata[15:0] == 16'h0003)
    |=> mode == PTP_MODE_ROT)
    else $error("code 3 did not select rotation mode");

  chk_func_pwm: assert property ( // R10
    regWr && (regAddr == `PTP_OFF_FUNC) && (hwdata[15:0] == 16'h0001)
    |=> mode == PTP_MODE_PWM)
    else $error("code 1 did not select pwm mode");

  chk_duty_full: assert property ( // R11
    (run && (mode == PTP_MODE_PWM) && (q.activeDuty == 7'h64))[*3] |-> q.pulsePri)
    else $error("full duty not continuously on");

  chk_duty_apply: assert property ( // R12
    (mode == PTP_MODE_PWM) && dutyOk |=> q.activeDuty == $past(q.dutySet[6:0]))
    else $error("valid duty not applied");

  chk_duty_bad: assert property ( // R15
    (mode == PTP_MODE_PWM) && !dutyOk
    |=> q.errFlags[`PTP_ERR_DUTY] && $stable(q.activeDuty))
    else $error("bad duty taken or not flagged");

  chk_width_err: assert property ( // R14
    (mode == PTP_MODE_PWM) && q.activeValid && (q.activeFreq == 16'h00C8) &&
    (q.dutySet == 16'h0001) |=> q.errFlags[`PTP_ERR_PWIDTH])
    else $error("short pulse width not flagged");

  chk_irq_level: assert property (
    |(q.irqStat & q.irqMask) |-> q.irq)
    else $error("interrupt low with unmasked status");

  // pin levels per mode, period restart on enable
  chk_rot_neg: assert property ( // R2
    (mode == PTP_MODE_ROT) && run && q.activeFreq[15] |=> !q.pulsePri)
    else $error("primary pulse for negative frequency");

  chk_dir_pos: assert property ( // R3
    (mode == PTP_MODE_STEP) && run && !q.activeFreq[15] |=> !q.pulseSec)
    else $error("direction high for positive frequency");

  chk_duty_zero: assert property ( // R11
    (run && (mode == PTP_MODE_PWM) && (q.activeDuty == 7'h00))[*3] |-> !q.pulsePri)
    else $error("zero duty not continuously off");

  chk_pwm_sec_idle: assert property ( // R11
    (mode == PTP_MODE_PWM) |=> !q.pulseSec)
    else $error("secondary output active in pwm mode");

  chk_idle_quiet: assert property ( // R16
    (mode == PTP_MODE_IDLE) |=> !q.pulsePri && !q.pulseSec)
    else $error("output active with no function selected");

  chk_restart_high: assert property ( // R16
    $rose(run) && modePulse |=> phaseOn)
    else $error("period did not restart on enable");

  // settings and flags
  chk_pwm_freq_hold: assert property ( // R13
    (mode == PTP_MODE_PWM) && q.enable |=> $stable(q.activeFreq))
    else $error("pwm frequency changed while enabled");

  chk_width_fast: assert property ( // R14
    (mode == PTP_MODE_PWM) && q.activeValid && (q.activeFreq == 16'h1388) &&
    (q.dutySet != 16'h0000) && (q.dutySet < 16'h0032) |=> q.errFlags[`PTP_ERR_PWIDTH])
    else $error("short pulse at top rate not flagged");

  chk_duty_clear: assert property ( // R8
    (mode == PTP_MODE_PWM) && (q.dutySet <= 16'h0064) |=> !q.errFlags[`PTP_ERR_DUTY])
    else $error("duty error stuck on valid duty");

  chk_freq_clear: assert property ( // R8
    modePulse && !q.enable && (q.freqSet == 16'hEC78) |=> !q.errFlags[`PTP_ERR_FREQ])
    else $error("frequency error stuck on valid setting");

  chk_stat_sticky: assert property (
    $rose(q.errFlags[`PTP_ERR_FREQ]) |-> q.irqStat[`PTP_ERR_FREQ])
    else $error("frequency error did not latch status");

  chk_wr_duty: assert property ( // R12
    regWr && (regAddr == `PTP_OFF_DUTY) |=> q.dutySet == $past(hwdata[15:0]))
    else $error("duty write did not land");

  // register bus: one wait state per transfer
  chk_bus_wait: assert property (
    hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not exactly one cycle");

  cov_rot_run: cover property (run && (mode == PTP_MODE_ROT) ##1 q.pulseSec);
  cov_step_run: cover property (run && (mode == PTP_MODE_STEP) ##1 q.pulsePri);
  cov_pwm_run: cover property (run && (mode == PTP_MODE_PWM) ##1 q.pulsePri);
  cov_freq_err: cover property (q.enable && modePulse && !freqOk);
  cov_width_err: cover property (q.errFlags[`PTP_ERR_PWIDTH]);

endmodule // ptp_pulse_unit

// *** sim/ptp_load_model.sv ***
// load model: measures pulse timing on the primary pin, counts rises on the secondary pin
module ptp_load_model (
  input wire logic clk_sys,
  input wire logic pulseOutPrimary,
  input wire logic pulseOutSecondary,
  output int rises,
  output int secRises,
  output int period,
  output int highLen
);
  timeunit 1ns;
  timeprecision 1ns;
  int t;
  logic p = 1'b0;
  logic s = 1'b0;
  int lastRise;
  // count rising edges, period and high time of the pulses
  always @(posedge clk_sys) begin
    t++;
    if (pulseOutPrimary && !p) begin
      period = t - lastRise;
      lastRise = t;
      rises++;
    end
    if (!pulseOutPrimary && p) highLen = t - lastRise;
    if (pulseOutSecondary && !s) secRises++;
    p = pulseOutPrimary;
    s = pulseOutSecondary;
  end
endmodule // ptp_load_model

// *** sim/ptp_pulse_unit_tb.sv ***
// self-checking bench for the pulse output unit
`include "ptp_defs.svh"
module ptp_pulse_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, pOut, sOut, irq;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'h4C86E44F;
  logic [31:0] mdl [8];
  int miscompares, n_checks, cyc, f;
  int rises, secRises, period, highLen;
  logic [31:0] r;

  ptp_pulse_unit dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pulseOutPrimary(pOut),
    .pulseOutSecondary(sOut), .irq(irq));
  ptp_load_model load (.clk_sys(clk_sys), .pulseOutPrimary(pOut), .pulseOutSecondary(sOut),
    .rises(rises), .secRises(secRises), .period(period), .highLen(highLen));

  // 50 mhz clock
  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // timing compare, one clock of phase jitter allowed
  task automatic chkNear(int got, int exp);
    n_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // single ahb-lite transfer, holds each phase until hready
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // write and keep the expected register image
  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d, r);
    if (a < 8'h10) mdl[a[4:2]] = d & (a == 8'h0C ? 32'h1 : 32'hFFFF);
    else if (a == 8'h18) mdl[6] = d & 32'h7;
    else if (a == 8'h14) mdl[5] = mdl[5] & ~d;
  endtask

  task automatic rd(logic [7:0] a);
    xfer(1'b0, a, 32'h0, r);
    chk(r, a > 8'h18 ? 32'h0 : mdl[a[4:2]]);
    chk(hresp, 32'h0);
  endtask

  // skip drops a first pulse cut short by a live duty change
  task automatic measure(int per, int hi, int skip);
    int r0;
    r0 = rises;
    repeat ((3 + skip) * per) begin
      @(posedge clk_sys);
      if (rises >= r0 + 2 + skip) break;
    end
    chkNear(period, per);
    chkNear(highLen, hi);
  endtask

  // cut a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    for (int i = 0; i < 8; i++) mdl[i] = 32'h0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // reset values, read-only and unmapped places
    wr(8'h1C, rnd());
    wr(`PTP_OFF_ERR, rnd());
    for (int i = 0; i < 8; i++) rd(8'(4 * i));
    $display("test registers done");
    // rotation mode, random rate then change while running
    f = 4000 + int'(rnd() % 1001);
    wr(`PTP_OFF_FREQ, 32'(f));
    wr(`PTP_OFF_FUNC, 32'h3);
    chk(pOut, 1'b0);
    wr(`PTP_OFF_CTRL, 32'h1);
    measure(`PTP_CLK_HZ / f, `PTP_CLK_HZ / f / 2, 0);
    wr(`PTP_OFF_FREQ, 32'h1388);
    wr(`PTP_OFF_FREQ, rnd() % 50);
    mdl[4] = 32'h4;
    mdl[5] = 32'h4;
    rd(`PTP_OFF_ERR);
    rd(`PTP_OFF_IRQSTAT);
    chk(irq, 1'b0);
    measure(10000, 5000, 0);
    chk(secRises, 0);
    wr(`PTP_OFF_FREQ, 32'hEC78);
    wr(`PTP_OFF_IRQMASK, 32'h4);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    rd(`PTP_OFF_ERR);
    wr(`PTP_OFF_FREQ, 32'h1388);
    mdl[4] = 32'h0;
    rd(`PTP_OFF_ERR);
    wr(`PTP_OFF_IRQSTAT, 32'h4);
    rd(`PTP_OFF_IRQSTAT);
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b0);
    wr(`PTP_OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk({pOut, sOut}, 2'b00);
    $display("test rotation done");
    // step mode, negative rate set while disabled
    wr(`PTP_OFF_FREQ, 32'hEC78);
    wr(`PTP_OFF_FUNC, 32'h4);
    wr(`PTP_OFF_CTRL, 32'h1);
    measure(10000, 5000, 0);
    chk(sOut, 1'b1);
    rd(`PTP_OFF_ERR);
    wr(`PTP_OFF_CTRL, 32'h0);
    $display("test step done");
    // pwm: duty changes while running, width and range errors
    wr(`PTP_OFF_FREQ, 32'h1388);
    wr(`PTP_OFF_FUNC, 32'h1);
    wr(`PTP_OFF_DUTY, 32'h0);
    wr(`PTP_OFF_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    chk(pOut, 1'b0);
    wr(`PTP_OFF_DUTY, 32'h32);
    measure(10000, 5000, 1);
    wr(`PTP_OFF_DUTY, 32'h1E);
    mdl[4] = 32'h1;
    mdl[5] = 32'h1;
    rd(`PTP_OFF_ERR);
    wr(`PTP_OFF_DUTY, 32'h32);
    mdl[4] = 32'h0;
    rd(`PTP_OFF_ERR);
    wr(`PTP_OFF_DUTY, 32'd101 + rnd() % 100);
    xfer(1'b0, `PTP_OFF_ERR, 32'h0, r);
    chk(r & 32'h2, 32'h2);
    mdl[5] = 32'h3;
    rd(`PTP_OFF_IRQSTAT);
    chk(irq, 1'b0);
    wr(`PTP_OFF_CTRL, 32'h0);
    $display("test pwm done");
    summarize();
  end
endmodule // ptp_pulse_unit_tb
